// ==== pmd_pkg.sv ====
// Package: port 0 latch and match detect constants and types
//
// Behaviour
// RULE1 - Compare-enable bit 0 excludes the pin from mismatch detection.
// RULE2 - Compare-enable bit 1 compares the pin with its expected-level bit.
// RULE3 - Expected-level 0 checks for low, 1 checks for high.
// RULE4 - Mismatch event is high while any compared pin differs; clears on match.
// RULE5 - Compare-enable bits reset to 0 and are readable and writable.
// RULE6 - Expected-level bits reset to 1 and are readable and writable.
// RULE7 - Output latch bit 0 drives the pin low.
// RULE8 - Latch bit 1 drives high in push-pull, else releases the pin.
// RULE9 - Output latch bits reset to 1 and are readable and writable.
// RULE10 - Output latch at 0x80 on every page, with single-bit access.
// RULE11 - Compare-enable at 0xFE, expected-level at 0xFD, pages 0x0 and 0x20.
// RULE12 - Reading the port returns actual pin levels for digital pins.
// RULE13 - Analog pins have pull-up, driver and receiver disabled.
// RULE14 - Comparison uses pin inputs synchronised on the system clock.
package pmd_pkg;
    localparam int PMD_WIDTH = 8;
    localparam logic [7:0] PMD_ADDR_LATCH = 8'h80;
    localparam logic [7:0] PMD_ADDR_EXPECT = 8'hFD;
    localparam logic [7:0] PMD_ADDR_CMPEN = 8'hFE;
    localparam logic [7:0] PMD_PAGE_BASE = 8'h00;
    localparam logic [7:0] PMD_PAGE_ALT = 8'h20;
    localparam logic [7:0] PMD_RST_LATCH = 8'hFF;
    localparam logic [7:0] PMD_RST_EXPECT = 8'hFF;
    localparam logic [7:0] PMD_RST_CMPEN = 8'h00;
    localparam logic [7:0] PMD_RST_INMODE = 8'hFF;
    localparam logic [7:0] PMD_RST_OUTMODE = 8'h00;
    localparam logic [2:0] PMD_BIT_MAX = 3'h7;

    // Special-function-register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_sel;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmd_sfr_req_t;

    typedef enum logic [1:0] {
        PMD_SEL_NONE = 2'b00,
        PMD_SEL_LATCH = 2'b01,
        PMD_SEL_EXPECT = 2'b10,
        PMD_SEL_CMPEN = 2'b11
    } pmd_sel_t;
endpackage

// ==== pmd_sync.sv ====
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/10ps
module pmd_sync
    import pmd_pkg::*;
#(
    parameter int WIDTH = PMD_WIDTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = clk_en ? async_in : stage1;
        next_sync_out = clk_en ? stage1 : sync_out;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// ==== pmd_port0.sv ====
// Port 0 output latch, compare registers and mismatch detector
`timescale 1ns/10ps
module pmd_port0
    import pmd_pkg::*;
#(
    parameter int WIDTH = PMD_WIDTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input pmd_sfr_req_t sfr_req,
    input wire logic [WIDTH-1:0] input_mode,
    input wire logic [WIDTH-1:0] output_mode,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_pullup_en,
    output logic [WIDTH-1:0] pin_rx_en,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic port_mismatch
);
    logic [WIDTH-1:0] port0_output_latch;
    logic [WIDTH-1:0] port0_expected_level;
    logic [WIDTH-1:0] port0_compare_enable;
    logic [WIDTH-1:0] next_latch;
    logic [WIDTH-1:0] next_expect;
    logic [WIDTH-1:0] next_cmpen;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] pin_level;
    logic [WIDTH-1:0] pin_differs;
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe;
    logic [WIDTH-1:0] next_pullup;
    logic [WIDTH-1:0] next_rx_en;
    logic [7:0] next_rdata;
    logic next_hit;
    logic next_mismatch;
    logic page_local;
    pmd_sel_t sel;

    ////////////////////////////////////////////////////////////////////
    // Pin input synchroniser
    pmd_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb begin
        page_local = (sfr_req.page == PMD_PAGE_BASE) ||
                     (sfr_req.page == PMD_PAGE_ALT); // RULE11
        if (sfr_req.addr == PMD_ADDR_LATCH) begin
            sel = PMD_SEL_LATCH; // RULE10
        end else if (page_local && sfr_req.addr == PMD_ADDR_EXPECT) begin
            sel = PMD_SEL_EXPECT; // RULE11
        end else if (page_local && sfr_req.addr == PMD_ADDR_CMPEN) begin
            sel = PMD_SEL_CMPEN; // RULE11
        end else begin
            sel = PMD_SEL_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes
    function automatic logic [WIDTH-1:0] wr_merge(
        input logic [WIDTH-1:0] cur,
        input pmd_sfr_req_t req
    );
        logic [WIDTH-1:0] res;
        res = cur;
        if (req.bit_op) begin
            res[req.bit_sel] = req.wdata[0];
        end else begin
            res = req.wdata[WIDTH-1:0];
        end
        return res;
    endfunction

    always_comb begin
        next_latch = port0_output_latch;
        next_expect = port0_expected_level;
        next_cmpen = port0_compare_enable;
        if (clk_en && sfr_req.wr) begin
            case (sel)
                PMD_SEL_LATCH: begin
                    next_latch = wr_merge(port0_output_latch, sfr_req); // RULE10
                end
                PMD_SEL_EXPECT: begin
                    next_expect = sfr_req.bit_op ? port0_expected_level :
                                  sfr_req.wdata[WIDTH-1:0]; // RULE6
                end
                PMD_SEL_CMPEN: begin
                    next_cmpen = sfr_req.bit_op ? port0_compare_enable :
                                 sfr_req.wdata[WIDTH-1:0]; // RULE5
                end
                default: begin
                    next_latch = port0_output_latch;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            port0_output_latch <= PMD_RST_LATCH; // RULE9
            port0_expected_level <= PMD_RST_EXPECT; // RULE6
            port0_compare_enable <= PMD_RST_CMPEN; // RULE5
        end else begin
            port0_output_latch <= next_latch;
            port0_expected_level <= next_expect;
            port0_compare_enable <= next_cmpen;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Synchronised pin level and per-pin compare
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_cmp
            always_comb begin
                pin_level[i] = input_mode[i] && pin_sync[i]; // RULE14 RULE12
                pin_differs[i] = port0_compare_enable[i] && // RULE1 RULE2
                    (pin_level[i] != port0_expected_level[i]); // RULE3
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Pin drive and receiver control
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_pin
            always_comb begin
                if (clk_en) begin
                    next_pin_out[i] = port0_output_latch[i]; // RULE7
                    next_pin_oe[i] = input_mode[i] && // RULE8 RULE13
                        (!port0_output_latch[i] || output_mode[i]);
                    next_pullup[i] = input_mode[i] && // RULE13
                        port0_output_latch[i] && !output_mode[i];
                    next_rx_en[i] = input_mode[i]; // RULE13
                end else begin
                    next_pin_out[i] = pin_out[i];
                    next_pin_oe[i] = pin_oe[i];
                    next_pullup[i] = pin_pullup_en[i];
                    next_rx_en[i] = pin_rx_en[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_out <= PMD_RST_LATCH;
            pin_oe <= '0;
            pin_pullup_en <= PMD_RST_INMODE;
            pin_rx_en <= PMD_RST_INMODE;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_pullup_en <= next_pullup;
            pin_rx_en <= next_rx_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read data and hit flag
    always_comb begin
        next_hit = sfr_hit;
        next_rdata = sfr_rdata;
        if (clk_en) begin
            next_hit = 1'b0;
        end
        if (clk_en && sfr_req.rd) begin
            next_hit = (sel != PMD_SEL_NONE);
            case (sel)
                PMD_SEL_LATCH: begin
                    next_rdata = 8'(pin_level); // RULE12
                end
                PMD_SEL_EXPECT: begin
                    next_rdata = 8'(port0_expected_level); // RULE6
                end
                PMD_SEL_CMPEN: begin
                    next_rdata = 8'(port0_compare_enable); // RULE5
                end
                default: begin
                    next_rdata = 8'h00; // RULE11
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else begin
            sfr_rdata <= next_rdata;
            sfr_hit <= next_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port mismatch detector
    always_comb begin
        next_mismatch = port_mismatch;
        if (clk_en) begin
            next_mismatch = |pin_differs; // RULE4
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            port_mismatch <= 1'b0;
        end else begin
            port_mismatch <= next_mismatch;
        end
    end
endmodule

// ==== pmd_monitor.sv ====
// Checker on the port 0 block ports
`timescale 1ns/10ps
module pmd_monitor
    import pmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input pmd_sfr_req_t sfr_req,
    input wire logic [7:0] input_mode,
    input wire logic [7:0] output_mode,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup_en,
    input wire logic [7:0] pin_rx_en,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic port_mismatch
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_mask_off;
        clk_en && sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == 8'hFE
        && sfr_req.page == 8'h00 && sfr_req.wdata == 8'h00
        ##1 (clk_en && !sfr_req.wr) [*2];
    endsequence
    chk_rx_mode: assert property (
        clk_en |=> pin_rx_en == $past(input_mode)) else $error("rx mode");
    chk_analog_off: assert property (
        ((pin_oe | pin_pullup_en) & ~pin_rx_en) == 8'h00) else $error("analog");
    chk_low_drive: assert property (
        (~pin_out & pin_rx_en & ~pin_oe) == 8'h00) else $error("low drive");
    chk_od_pullup: assert property (
        (pin_oe & pin_pullup_en) == 8'h00) else $error("pullup");
    chk_latch_hit: assert property (
        clk_en && sfr_req.rd && sfr_req.addr == 8'h80 |=> sfr_hit)
        else $error("latch hit");
    chk_page_miss: assert property (
        clk_en && sfr_req.rd && sfr_req.addr == 8'hFE && sfr_req.page != 8'h00
        && sfr_req.page != 8'h20 |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("page miss");
    chk_mask_quiet: assert property (
        s_mask_off |=> !port_mismatch) else $error("mask off");
    chk_sync_settle: assert property (
        (clk_en && !sfr_req.wr && $stable(pin_in) && $stable(input_mode)) [*4]
        |=> $stable(port_mismatch)) else $error("settle");
endmodule

// ==== pmd_pins_model.sv ====
// External circuitry on the port 0 pins
`timescale 1ns/10ps
module pmd_pins_model (
    input wire logic core_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup_en,
    input wire logic [7:0] drv,
    input wire logic [7:0] val,
    output logic [7:0] pin_in
);
    logic [7:0] last_lvl;
    logic [7:0] held;
    assign held = pin_oe | drv | pin_pullup_en;
    always_ff @(posedge core_clk) begin
        last_lvl <= (held & pin_in) | (~held & last_lvl);
    end
    // A floating pin shows the inverse of its last held level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv & val)
        | (~pin_oe & ~drv & (pin_pullup_en | ~last_lvl));
endmodule

// ==== tb_top.sv ====
// Testbench for the port 0 block
`timescale 1ns/10ps
module tb_top
    import pmd_pkg::*;
;
    logic core_clk = 0, nrst = 0, clk_en = 1, hit, mism;
    pmd_sfr_req_t req = '0;
    logic [7:0] in_mode = 8'hFF, out_mode = 8'h00, drv = 8'h00, val = 8'h00;
    logic [7:0] pin_in, pin_out, pin_oe, pull, rx_en, rdata;
    int num_errors = 0, tests_run = 0;
    pmd_port0 pmd_port0_i (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
        .sfr_req(req), .input_mode(in_mode), .output_mode(out_mode),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pull), .pin_rx_en(rx_en), .sfr_rdata(rdata),
        .sfr_hit(hit), .port_mismatch(mism));
    pmd_pins_model pmd_pins_model_i (.core_clk(core_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pull), .drv(drv), .val(val),
        .pin_in(pin_in));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] pg, ad, dt, input logic bop = 1'h0,
            input logic [2:0] sel = 3'h0);
        @(negedge core_clk);
        req = {1'h1, 1'h0, bop, sel, pg, ad, dt};
        @(negedge core_clk);
        req = '0;
    endtask
    task rd(input logic [7:0] pg, ad, exp, input logic eh);
        @(negedge core_clk);
        req = {1'h0, 1'h1, 1'h0, 3'h0, pg, ad, 8'h00};
        @(negedge core_clk);
        req = '0;
        chk(rdata, exp);
        chk({7'h00, hit}, {7'h00, eh});
    endtask
    task print_verdict;
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        print_verdict;
    end
    initial begin
        repeat (12) @(negedge core_clk);
        nrst = 1;
        chk(pin_out, 8'hFF);
        rd(8'h00, 8'hFE, 8'h00, 1'h1);
        rd(8'h20, 8'hFD, 8'hFF, 1'h1);
        rd(8'h07, 8'h80, 8'hFF, 1'h1);
        rd(8'h07, 8'hFE, 8'h00, 1'h0);
        rd(8'h00, 8'h81, 8'h00, 1'h0);
        wr(8'h05, 8'h80, 8'h5A);
        wr(8'h00, 8'h80, 8'h01, 1'h1, 3'h7);
        wr(8'h00, 8'hFE, 8'h01, 1'h1, 3'h0);
        rd(8'h00, 8'hFE, 8'h00, 1'h1);
        repeat (4) @(negedge core_clk);
        chk(pin_out, 8'hDA);
        chk(pin_oe, 8'h25);
        rd(8'h00, 8'h80, 8'hDA, 1'h1);
        out_mode = 8'hFF;
        repeat (3) @(negedge core_clk);
        chk(pin_oe, 8'hFF);
        chk(pull, 8'h00);
        rd(8'h00, 8'h80, 8'hDA, 1'h1);
        out_mode = 8'h00;
        wr(8'h00, 8'h80, 8'hFF);
        drv = 8'hFF;
        val = 8'h0F;
        for (int i = 0; i < 8; i++) begin
            wr(8'h20, 8'hFE, 8'h01 << i);
            wr(8'h00, 8'hFD, val);
            repeat (4) @(negedge core_clk);
            chk({7'h00, mism}, 8'h00);
            wr(8'h20, 8'hFD, ~val);
            repeat (4) @(negedge core_clk);
            chk({7'h00, mism}, 8'h01);
        end
        wr(8'h00, 8'hFE, 8'h00);
        repeat (4) @(negedge core_clk);
        chk({7'h00, mism}, 8'h00);
        wr(8'h00, 8'hFE, 8'hFF);
        wr(8'h00, 8'hFD, 8'hF0);
        rd(8'h20, 8'hFD, 8'hF0, 1'h1);
        rd(8'h00, 8'hFE, 8'hFF, 1'h1);
        repeat (4) @(negedge core_clk);
        chk({7'h00, mism}, 8'h01);
        val = 8'hF0;
        repeat (4) @(negedge core_clk);
        chk({7'h00, mism}, 8'h00);
        in_mode = 8'hFE;
        val = 8'hF1;
        repeat (4) @(negedge core_clk);
        chk({7'h00, mism}, 8'h00);
        chk(rx_en, 8'hFE);
        chk(pull, 8'hFE);
        rd(8'h00, 8'h80, 8'hF0, 1'h1);
        clk_en = 1'b0;
        val = 8'h0F;
        wr(8'h00, 8'h80, 8'h00);
        repeat (4) @(negedge core_clk);
        chk({7'h00, mism}, 8'h00);
        chk(pin_out, 8'hFF);
        clk_en = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({7'h00, mism}, 8'h01);
        chk(pin_out, 8'hFF);
        wr(8'h00, 8'h80, 8'h00);
        repeat (2) @(negedge core_clk);
        chk(pin_out, 8'h00);
        nrst = 1'b0;
        @(negedge core_clk);
        chk(pin_out, 8'hFF);
        chk({7'h00, mism}, 8'h00);
        nrst = 1'b1;
        rd(8'h20, 8'hFE, 8'h00, 1'h1);
        rd(8'h00, 8'hFD, 8'hFF, 1'h1);
        print_verdict;
    end
endmodule
bind pmd_port0 pmd_monitor pmd_monitor_i (.core_clk(core_clk), .nrst(nrst),
    .clk_en(clk_en), .sfr_req(sfr_req), .input_mode(input_mode),
    .output_mode(output_mode), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_rx_en(pin_rx_en),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .port_mismatch(port_mismatch));
